// ### core/dsi_defs.svh
/*
 * Constants of the drive status and interlock block: register offsets,
 * field positions, reset values, function-select codes and timing counts.
 * Assumes a 200 MHz system clock and a plain one-cycle register port.
 */
// Overview of operation
// [R1] A protective trip raises the fault status output.
// [R2] Negative logic on the fault output means active while healthy.
// [R3] The ready output rises once the drive is powered and operable.
// [R4] The running output holds through deceleration until output stops.
// [R5] Current detection is active while operating above the set level.
// [R6] The detection level resets to 150 percent and is writable.
// [R7] For interlock use the operator lowers the level to about 20 percent.
// [R8] Codes are fault 99, ready 11, running 0, current 12; plus 100 inverts.
// [R9] By default fault drives the relay terminal, running its own terminal.
// [R10] A new code on a terminal replaces its previous function.
// [R11] The interlock controller checks that ready appears after power-up.
// [R12] The controller checks running during start, allowing deceleration.
// [R13] The controller checks current detection, allowing deceleration.
// [R14] A backup checker compares start with measured speed or current.
// [R15] A backup checker flags commanded versus measured speed mismatch; the model has no speed input and only flags zero MOTOR_CURRENT_IN during start.
// [R16] The controller alarms on disagreement longer than the allowance.
`ifndef DSI_DEFS_SVH
`define DSI_DEFS_SVH

// Register offsets (byte addresses, 8-bit address port)
`define DSI_REG_CTRL 8'h00
`define DSI_REG_STATUS 8'h04
`define DSI_REG_LEVEL 8'h08
`define DSI_REG_SEL_RELAY 8'h0C
`define DSI_REG_SEL_RUN 8'h10
`define DSI_REG_SEL_OPEN 8'h14
`define DSI_REG_EVENT 8'h18
`define DSI_REG_MASK 8'h1C
`define DSI_REG_DECEL 8'h20

// Control register fields
`define DSI_CTRL_TRIP 0
`define DSI_CTRL_RESET_FAULT 1

// Event bit positions
`define DSI_EV_TRIP 0
`define DSI_EV_READY 1
`define DSI_EV_RUN_START 2
`define DSI_EV_RUN_STOP 3
`define DSI_EV_OVERCUR 4

// Output function-select codes
`define DSI_CODE_RUN 8'h00
`define DSI_CODE_READY 8'h0B
`define DSI_CODE_CURRENT 8'h0C
`define DSI_CODE_FAULT 8'h63
`define DSI_CODE_NEG 8'h64

// Reset values
`define DSI_LEVEL_RESET 16'h0096
`define DSI_SEL_RELAY_RESET 8'h63
`define DSI_SEL_RUN_RESET 8'h00
`define DSI_SEL_OPEN_RESET 8'h0C
`define DSI_DECEL_RESET 16'h0064

// Timing: power-up settling before ready, and decel tick period
`define DSI_CLK_MHZ 200
`define DSI_READY_US 10
`define DSI_READY_CYC (`DSI_READY_US * `DSI_CLK_MHZ)
`define DSI_TICK_NS 1000
`define DSI_TICK_CYC (`DSI_TICK_NS * `DSI_CLK_MHZ / 1000)

`endif

// ### core/dsi_pkg.sv
/*
 * Types of the drive status and interlock block.
 * Assumes dsi_defs.svh is included by each user for the constants.
 */
package dsi_pkg;

    // Drive operating states
    typedef enum logic [1:0] {
        DSI_IDLE,
        DSI_RUN,
        DSI_DECEL,
        DSI_TRIPPED
    } dsi_state_t;

    // Internal status functions that a terminal may carry
    typedef struct packed {
        logic fault;
        logic ready;
        logic running;
        logic current;
    } dsi_func_t;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } dsi_bus_req_t;

endpackage

// ### core/dsi_term_sel.sv
/*
 * One output terminal: maps a function-select code onto one status
 * function with positive or negative logic.
 * Assumes codes come from a register; an unknown code drives inactive.
 */
`include "dsi_defs.svh"

module dsi_term_sel (
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // Selection and functions
    input wire logic [7:0] SEL,
    input wire dsi_pkg::dsi_func_t FUNC,
    // Terminal level
    output logic TERM
);
    import dsi_pkg::*;

    logic [7:0] base;
    logic neg;
    logic next_term;

    // Split the code into function and polarity
    assign neg = (SEL >= `DSI_CODE_NEG);
    assign base = neg ? SEL - `DSI_CODE_NEG : SEL;

    // [R8] Code decode with inversion
    // [R10] Only the selected function reaches the pin
    always_comb begin
        next_term = 1'b0;
        if (base == `DSI_CODE_FAULT) begin
            next_term = FUNC.fault;
        end else if (base == `DSI_CODE_READY) begin
            next_term = FUNC.ready;
        end else if (base == `DSI_CODE_RUN) begin
            next_term = FUNC.running;
        end else if (base == `DSI_CODE_CURRENT) begin
            next_term = FUNC.current;
        end
        // [R2] Inversion for negative logic
        if (neg) begin
            next_term = ~next_term;
        end
    end

    // Registered so the pin never glitches on a code change
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            TERM <= 1'b0;
        end else begin
            TERM <= next_term;
        end
    end

endmodule

// ### core/dsi_tick.sv
/*
 * Divider giving a one-cycle enable pulse every PERIOD clocks.
 * Assumes a single free-running clock.
 */
module dsi_tick #(
    parameter int PERIOD = 200
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // Enable pulse
    output logic TICK
);
    import dsi_pkg::*;

    // Elaboration check: the counter is 16 bits wide
    if (PERIOD < 2 || PERIOD > 65535) begin
        $error("dsi_tick: PERIOD out of range");
    end

    logic [15:0] count;

    // Count up and pulse on wrap
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            count <= 16'h0000;
            TICK <= 1'b0;
        end else if (count == 16'(PERIOD - 1)) begin
            count <= 16'h0000;
            TICK <= 1'b1;
        end else begin
            count <= count + 16'h0001;
            TICK <= 1'b0;
        end
    end

endmodule

// ### core/dsi_core.sv
/*
 * Drive status and interlock output logic: fault, ready, running and
 * current-detect status, three output terminals with selectable function,
 * register port, sticky events with mask and one interrupt line.
 * Assumes start inputs and current measurement synchronous to CLK, and a
 * register master that never issues read and write together.
 */
`include "dsi_defs.svh"

module dsi_core #(
    parameter int READY_CYC = `DSI_READY_CYC,
    parameter int TICK_CYC = `DSI_TICK_CYC
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // Start commands and drive feedback
    input wire logic FORWARD_START_IN,
    input wire logic REVERSE_START_IN,
    input wire logic PROTECT_TRIP_IN,
    input wire logic [15:0] MOTOR_CURRENT_IN,
    // Register port
    input wire dsi_pkg::dsi_bus_req_t BUS_REQ,
    output logic [31:0] BUS_RDATA,
    // Output terminals
    output logic FAULT_RELAY_TERMINAL,
    output logic RUNNING_TERMINAL,
    output logic OPEN_COLLECTOR_TERMINAL,
    // Raw status and interrupt
    output logic FAULT_OUT,
    output logic DRIVE_READY_OUT,
    output logic RUNNING_OUT,
    output logic CURRENT_DETECT_OUT,
    output logic IRQ
);
    import dsi_pkg::*;

    // Elaboration check: the ready counter is 20 bits wide
    if (READY_CYC < 1 || READY_CYC > 1048575) begin
        $error("dsi_core: READY_CYC out of range");
    end

    dsi_state_t state;
    dsi_state_t next_state;
    dsi_func_t func;
    logic start;
    logic tick;
    logic ready;
    logic [19:0] ready_count;
    logic [15:0] current_detect_level;
    logic [15:0] decel_time;
    logic [15:0] decel_count;
    logic [7:0] sel_relay;
    logic [7:0] sel_run;
    logic [7:0] sel_open;
    logic [4:0] event_status;
    logic [4:0] event_mask;
    logic [4:0] event_set;
    logic sw_trip;
    logic fault_clear;
    logic overcur;
    logic overcur_d;
    logic running_d;
    logic ready_d;
    logic operating;
    logic wr_ctrl;

    assign start = FORWARD_START_IN | REVERSE_START_IN;
    assign wr_ctrl = BUS_REQ.wr && (BUS_REQ.addr == `DSI_REG_CTRL);
    assign fault_clear = wr_ctrl && BUS_REQ.wdata[`DSI_CTRL_RESET_FAULT];

    // Slow tick paces the deceleration countdown
    dsi_tick #(
        .PERIOD(TICK_CYC)
    ) u_tick (
        .CLK(CLK),
        .NRST(NRST),
        .TICK(tick)
    );

    // [R3] Ready after power-up settling time
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ready_count <= 20'h00000;
            ready <= 1'b0;
        end else if (ready_count == 20'(READY_CYC - 1)) begin
            ready <= 1'b1;
        end else begin
            ready_count <= ready_count + 20'h00001;
        end
    end

    // Drive state machine
    always_comb begin
        next_state = state;
        case (state)
            DSI_IDLE: begin
                if (start && ready) begin
                    next_state = DSI_RUN;
                end
            end
            DSI_RUN: begin
                if (!start) begin
                    next_state = DSI_DECEL;
                end
            end
            DSI_DECEL: begin
                if (start) begin
                    next_state = DSI_RUN;
                end else if (decel_count == 16'h0000) begin
                    next_state = DSI_IDLE;
                end
            end
            DSI_TRIPPED: begin
                if (fault_clear) begin
                    next_state = DSI_IDLE;
                end
            end
            default: begin
                next_state = DSI_IDLE;
            end
        endcase
        // [R1] Trip overrides any running state
        if (PROTECT_TRIP_IN || sw_trip) begin
            next_state = DSI_TRIPPED;
        end
    end

    // State register
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            state <= DSI_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // [R4] Deceleration countdown keeps running active until stop
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            decel_count <= 16'h0000;
        end else if (state == DSI_RUN) begin
            decel_count <= decel_time;
        end else if (state == DSI_DECEL && tick &&
                     decel_count != 16'h0000) begin
            decel_count <= decel_count - 16'h0001;
        end
    end

    // [R5] Current detection only while output is live
    assign operating = (state == DSI_RUN) || (state == DSI_DECEL);
    assign overcur = operating && (MOTOR_CURRENT_IN > current_detect_level);

    // Functions offered to the terminals
    always_comb begin
        func.fault = (state == DSI_TRIPPED);
        func.ready = ready && (state != DSI_TRIPPED);
        func.running = operating;
        func.current = overcur;
    end

    // Raw status outputs, registered
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            FAULT_OUT <= 1'b0;
            DRIVE_READY_OUT <= 1'b0;
            RUNNING_OUT <= 1'b0;
            CURRENT_DETECT_OUT <= 1'b0;
        end else begin
            FAULT_OUT <= func.fault;
            DRIVE_READY_OUT <= func.ready;
            RUNNING_OUT <= func.running;
            CURRENT_DETECT_OUT <= func.current;
        end
    end

    // [R9] Relay terminal, fault by default
    dsi_term_sel u_relay (
        .CLK(CLK),
        .NRST(NRST),
        .SEL(sel_relay),
        .FUNC(func),
        .TERM(FAULT_RELAY_TERMINAL)
    );

    // [R9] Running terminal, running by default
    dsi_term_sel u_run (
        .CLK(CLK),
        .NRST(NRST),
        .SEL(sel_run),
        .FUNC(func),
        .TERM(RUNNING_TERMINAL)
    );

    // Open-collector terminal, current detect by default
    dsi_term_sel u_open (
        .CLK(CLK),
        .NRST(NRST),
        .SEL(sel_open),
        .FUNC(func),
        .TERM(OPEN_COLLECTOR_TERMINAL)
    );

    // Software trip is a one-cycle request
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            sw_trip <= 1'b0;
        end else begin
            sw_trip <= wr_ctrl && BUS_REQ.wdata[`DSI_CTRL_TRIP];
        end
    end

    // [R6] Detection level and setting registers
    // [R10] Writing a code replaces the terminal function
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            current_detect_level <= `DSI_LEVEL_RESET;
            sel_relay <= `DSI_SEL_RELAY_RESET;
            sel_run <= `DSI_SEL_RUN_RESET;
            sel_open <= `DSI_SEL_OPEN_RESET;
            decel_time <= `DSI_DECEL_RESET;
            event_mask <= 5'h00;
        end else if (BUS_REQ.wr) begin
            if (BUS_REQ.addr == `DSI_REG_LEVEL) begin
                current_detect_level <= BUS_REQ.wdata[15:0];
            end else if (BUS_REQ.addr == `DSI_REG_SEL_RELAY) begin
                sel_relay <= BUS_REQ.wdata[7:0];
            end else if (BUS_REQ.addr == `DSI_REG_SEL_RUN) begin
                sel_run <= BUS_REQ.wdata[7:0];
            end else if (BUS_REQ.addr == `DSI_REG_SEL_OPEN) begin
                sel_open <= BUS_REQ.wdata[7:0];
            end else if (BUS_REQ.addr == `DSI_REG_DECEL) begin
                decel_time <= BUS_REQ.wdata[15:0];
            end else if (BUS_REQ.addr == `DSI_REG_MASK) begin
                event_mask <= BUS_REQ.wdata[4:0];
            end
        end
    end

    // Edge history for events
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            overcur_d <= 1'b0;
            running_d <= 1'b0;
            ready_d <= 1'b0;
        end else begin
            overcur_d <= overcur;
            running_d <= func.running;
            ready_d <= func.ready;
        end
    end

    always_comb begin
        event_set = 5'h00;
        event_set[`DSI_EV_TRIP] = (next_state == DSI_TRIPPED) &&
                                  (state != DSI_TRIPPED);
        event_set[`DSI_EV_READY] = func.ready && !ready_d;
        event_set[`DSI_EV_RUN_START] = func.running && !running_d;
        event_set[`DSI_EV_RUN_STOP] = !func.running && running_d;
        event_set[`DSI_EV_OVERCUR] = overcur && !overcur_d;
    end

    // Sticky events, write one to clear; a new event wins over the clear
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            event_status <= 5'h00;
        end else if (BUS_REQ.wr && BUS_REQ.addr == `DSI_REG_EVENT) begin
            event_status <= (event_status & ~BUS_REQ.wdata[4:0]) | event_set;
        end else begin
            event_status <= event_status | event_set;
        end
    end

    // Level interrupt, held while any unmasked event is set
    assign IRQ = |(event_status & event_mask);

    // Read port, data valid the cycle after the strobe
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            BUS_RDATA <= 32'h00000000;
        end else if (BUS_REQ.rd) begin
            if (BUS_REQ.addr == `DSI_REG_CTRL) begin
                BUS_RDATA <= 32'h00000000;
            end else if (BUS_REQ.addr == `DSI_REG_STATUS) begin
                BUS_RDATA <= {26'h0, state,
                              func.fault, func.ready,
                              func.running, func.current};
            end else if (BUS_REQ.addr == `DSI_REG_LEVEL) begin
                BUS_RDATA <= {16'h0000, current_detect_level};
            end else if (BUS_REQ.addr == `DSI_REG_SEL_RELAY) begin
                BUS_RDATA <= {24'h000000, sel_relay};
            end else if (BUS_REQ.addr == `DSI_REG_SEL_RUN) begin
                BUS_RDATA <= {24'h000000, sel_run};
            end else if (BUS_REQ.addr == `DSI_REG_SEL_OPEN) begin
                BUS_RDATA <= {24'h000000, sel_open};
            end else if (BUS_REQ.addr == `DSI_REG_EVENT) begin
                BUS_RDATA <= {27'h0, event_status};
            end else if (BUS_REQ.addr == `DSI_REG_MASK) begin
                BUS_RDATA <= {27'h0, event_mask};
            end else if (BUS_REQ.addr == `DSI_REG_DECEL) begin
                BUS_RDATA <= {16'h0000, decel_time};
            end else begin
                BUS_RDATA <= 32'h00000000;
            end
        end else begin
            BUS_RDATA <= 32'h00000000;
        end
    end

endmodule

// ### dv/dsi_props.sv
/* Port assertions for dsi_core.
   Assumes one clock CLK and the async active-low reset NRST. */
`include "dsi_defs.svh"

module dsi_props #(
    parameter int READY_CYC = `DSI_READY_CYC
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // Inputs watched
    input wire logic FORWARD_START_IN,
    input wire logic REVERSE_START_IN,
    input wire logic PROTECT_TRIP_IN,
    input wire dsi_pkg::dsi_bus_req_t BUS_REQ,
    // Outputs watched
    input wire logic FAULT_RELAY_TERMINAL,
    input wire logic RUNNING_TERMINAL,
    input wire logic OPEN_COLLECTOR_TERMINAL,
    input wire logic FAULT_OUT,
    input wire logic DRIVE_READY_OUT,
    input wire logic RUNNING_OUT,
    input wire logic CURRENT_DETECT_OUT
);
    import dsi_pkg::*;
    logic [15:0] up;
    logic [7:0] s_relay;
    logic [7:0] s_run;
    logic [7:0] s_open;
    logic [3:0] f;
    logic st;

    // Raw functions in select order, and any start
    assign f = {FAULT_OUT, DRIVE_READY_OUT, RUNNING_OUT, CURRENT_DETECT_OUT};
    assign st = FORWARD_START_IN | REVERSE_START_IN;

    // Cycles since reset release, saturating
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) up <= 16'h0000;
        else if (up != 16'hFFFF) up <= up + 16'h0001;
    end

    // Shadow of the three select registers
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            s_relay <= `DSI_SEL_RELAY_RESET;
            s_run <= `DSI_SEL_RUN_RESET;
            s_open <= `DSI_SEL_OPEN_RESET;
        end else if (BUS_REQ.wr) begin
            if (BUS_REQ.addr == `DSI_REG_SEL_RELAY)
                s_relay <= BUS_REQ.wdata[7:0];
            if (BUS_REQ.addr == `DSI_REG_SEL_RUN) s_run <= BUS_REQ.wdata[7:0];
            if (BUS_REQ.addr == `DSI_REG_SEL_OPEN) s_open <= BUS_REQ.wdata[7:0];
        end
    end

    // Expected terminal level; unknown codes stay inactive
    function automatic logic term_exp(logic [7:0] s, logic [3:0] v);
        logic n;
        logic [7:0] b;
        n = (s >= `DSI_CODE_NEG);
        b = n ? s - `DSI_CODE_NEG : s;
        case (b)
            `DSI_CODE_FAULT: term_exp = v[3] ^ n;
            `DSI_CODE_READY: term_exp = v[2] ^ n;
            `DSI_CODE_RUN: term_exp = v[1] ^ n;
            `DSI_CODE_CURRENT: term_exp = v[0] ^ n;
            default: term_exp = n;
        endcase
    endfunction

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);

    a_trip_fault: assert property (PROTECT_TRIP_IN |-> ##[1:3] FAULT_OUT)
        else $error("fault output missed a trip");
    a_ready_early: assert property (up < READY_CYC |-> !DRIVE_READY_OUT)
        else $error("ready rose before settling");
    a_ready_timely: assert property (up == READY_CYC + 3 && !FAULT_OUT
        |-> DRIVE_READY_OUT)
        else $error("ready late after reset");
    a_run_follows: assert property ($rose(st) && DRIVE_READY_OUT
        && !FAULT_OUT && !PROTECT_TRIP_IN && !$past(PROTECT_TRIP_IN)
        && !BUS_REQ.wr && !$past(BUS_REQ.wr) |-> ##[1:3] RUNNING_OUT)
        else $error("running did not follow start");
    a_run_holds: assert property ($fell(RUNNING_OUT)
        |-> FAULT_OUT || !$past(st, 2))
        else $error("running fell while start held");
    a_curr_run: assert property (CURRENT_DETECT_OUT |-> RUNNING_OUT)
        else $error("current detect outside operation");
    a_relay_map: assert property (up > 2 && s_relay == $past(s_relay)
        |-> FAULT_RELAY_TERMINAL == term_exp(s_relay, f))
        else $error("relay terminal wrong");
    a_run_map: assert property (up > 2 && s_run == $past(s_run)
        |-> RUNNING_TERMINAL == term_exp(s_run, f))
        else $error("running terminal wrong");
    a_open_map: assert property (up > 2 && s_open == $past(s_open)
        |-> OPEN_COLLECTOR_TERMINAL == term_exp(s_open, f))
        else $error("open collector terminal wrong");

    // Main scenarios reached
    c_run: cover property ($rose(RUNNING_OUT));
    c_stop: cover property ($fell(RUNNING_OUT) && !FAULT_OUT);
    c_trip: cover property ($rose(FAULT_OUT));
    c_neg: cover property (s_open >= `DSI_CODE_NEG && OPEN_COLLECTOR_TERMINAL);
endmodule

bind dsi_core dsi_props #(.READY_CYC(READY_CYC)) i_dsi_props (
    .CLK(CLK), .NRST(NRST), .FORWARD_START_IN(FORWARD_START_IN),
    .REVERSE_START_IN(REVERSE_START_IN), .PROTECT_TRIP_IN(PROTECT_TRIP_IN),
    .BUS_REQ(BUS_REQ), .FAULT_RELAY_TERMINAL(FAULT_RELAY_TERMINAL),
    .RUNNING_TERMINAL(RUNNING_TERMINAL),
    .OPEN_COLLECTOR_TERMINAL(OPEN_COLLECTOR_TERMINAL), .FAULT_OUT(FAULT_OUT),
    .DRIVE_READY_OUT(DRIVE_READY_OUT), .RUNNING_OUT(RUNNING_OUT),
    .CURRENT_DETECT_OUT(CURRENT_DETECT_OUT));

// ### dv/dsi_ictl_model.sv
/* Interlock controller model: issues start commands and watches status.
   Assumes the bench supplies requests and the measured motor current. */
module dsi_ictl_model (
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // Requests from the bench
    input wire logic [1:0] RUN_REQ,
    input wire logic CUR_CHK,
    input wire logic [7:0] ALLOW,
    // Drive status and measurement
    input wire logic DRIVE_READY_OUT,
    input wire logic RUNNING_OUT,
    input wire logic CURRENT_DETECT_OUT,
    input wire logic [15:0] MOTOR_CURRENT_IN,
    // Start commands and alarm
    output logic FORWARD_START_IN,
    output logic REVERSE_START_IN,
    output logic ALARM
);
    logic seen_ready;
    logic bad;
    logic [7:0] gap;

    // starts held back until ready seen
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            seen_ready <= 1'b0;
            FORWARD_START_IN <= 1'b0;
            REVERSE_START_IN <= 1'b0;
        end else begin
            if (DRIVE_READY_OUT) seen_ready <= 1'b1;
            FORWARD_START_IN <= seen_ready & RUN_REQ[0];
            REVERSE_START_IN <= seen_ready & RUN_REQ[1] & ~RUN_REQ[0];
        end
    end

    // start against running, detection, measured motion
    assign bad = (FORWARD_START_IN | REVERSE_START_IN) ?
        (!RUNNING_OUT || (CUR_CHK && !CURRENT_DETECT_OUT)
        || MOTOR_CURRENT_IN == 16'h0000) : (RUNNING_OUT || CURRENT_DETECT_OUT);

    // sticky alarm once disagreement outlasts allowance
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            gap <= 8'h00;
            ALARM <= 1'b0;
        end else begin
            gap <= !bad ? 8'h00 : (gap == 8'hFF) ? gap : gap + 8'h01;
            if (gap > ALLOW) ALARM <= 1'b1;
        end
    end
endmodule

// ### dv/tb_drive_status_interlock.sv
/* Self-checking bench for dsi_core with the interlock controller model.
   Assumes short ready and tick parameters to keep the run brief. */
module tb_drive_status_interlock;
    timeunit 1ns;
    timeprecision 1ps;
    import dsi_pkg::*;
    localparam int TICK = 2;
    logic CLK = 1'b0, NRST = 1'b0, PROTECT_TRIP_IN = 1'b0, CUR_CHK = 1'b0;
    logic FORWARD_START_IN, REVERSE_START_IN, ALARM, IRQ;
    logic FAULT_RELAY_TERMINAL, RUNNING_TERMINAL, OPEN_COLLECTOR_TERMINAL;
    logic FAULT_OUT, DRIVE_READY_OUT, RUNNING_OUT, CURRENT_DETECT_OUT;
    logic [1:0] RUN_REQ = 2'h0;
    logic [15:0] MOTOR_CURRENT_IN = 16'h0000;
    logic [15:0] lvl, c;
    logic [31:0] BUS_RDATA, seed;
    dsi_bus_req_t BUS_REQ = '0;
    int errors = 0, comparisons = 0, n;
    logic [7:0] ra [8] = '{8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C, 8'h20, 8'h00,
        8'h24};
    logic [31:0] rv [8] = '{32'h96, 32'h63, 32'h0, 32'h0C, 32'h0, 32'h64,
        32'h0, 32'h0};
    logic [7:0] codes [4] = '{8'h63, 8'h0B, 8'h00, 8'h0C};

    // Clock of 5 ns
    always #2.5 CLK = ~CLK;

    dsi_core #(.READY_CYC(4), .TICK_CYC(TICK)) i_dsi_core (.CLK(CLK),
        .NRST(NRST), .FORWARD_START_IN(FORWARD_START_IN),
        .REVERSE_START_IN(REVERSE_START_IN), .PROTECT_TRIP_IN(PROTECT_TRIP_IN),
        .MOTOR_CURRENT_IN(MOTOR_CURRENT_IN), .BUS_REQ(BUS_REQ),
        .BUS_RDATA(BUS_RDATA), .FAULT_RELAY_TERMINAL(FAULT_RELAY_TERMINAL),
        .RUNNING_TERMINAL(RUNNING_TERMINAL),
        .OPEN_COLLECTOR_TERMINAL(OPEN_COLLECTOR_TERMINAL),
        .FAULT_OUT(FAULT_OUT), .DRIVE_READY_OUT(DRIVE_READY_OUT),
        .RUNNING_OUT(RUNNING_OUT), .CURRENT_DETECT_OUT(CURRENT_DETECT_OUT),
        .IRQ(IRQ));

    dsi_ictl_model i_dsi_ictl_model (.CLK(CLK), .NRST(NRST),
        .RUN_REQ(RUN_REQ), .CUR_CHK(CUR_CHK), .ALLOW(8'h1E),
        .DRIVE_READY_OUT(DRIVE_READY_OUT), .RUNNING_OUT(RUNNING_OUT),
        .CURRENT_DETECT_OUT(CURRENT_DETECT_OUT),
        .MOTOR_CURRENT_IN(MOTOR_CURRENT_IN),
        .FORWARD_START_IN(FORWARD_START_IN),
        .REVERSE_START_IN(REVERSE_START_IN), .ALARM(ALARM));

    // Compare and report at once
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One bus cycle; read data stands in the cycle after the strobe
    task automatic bus(logic [7:0] a, logic [31:0] d, logic w);
        @(posedge CLK);
        BUS_REQ <= '{a, d, w, !w};
        @(posedge CLK);
        BUS_REQ <= '0;
        #1;
    endtask

    task automatic rd(logic [7:0] a, logic [31:0] exp);
        bus(a, 32'h0, 1'b0);
        chk(BUS_RDATA, exp);
    endtask

    task automatic cyc(int k);
        repeat (k) @(posedge CLK);
        #1;
    endtask

    task automatic conclude();
        if (errors == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Watchdog well beyond the expected run
    initial begin
        #100000;
        errors++;
        conclude();
    end

    // Main sequence
    initial begin
        seed = $urandom(27);
        repeat (2) @(posedge CLK);
        NRST <= 1'b1;
        // reset values, unmapped place reads zero
        foreach (ra[i]) rd(ra[i], rv[i]);
        for (n = 0; n < 40 && DRIVE_READY_OUT !== 1'b1; n++) cyc(1);
        rd(8'h04, 32'h4);
        bus(8'h20, 32'h3, 1'b1);
        for (int k = 0; k < 6; k++) begin
            lvl = 16'($urandom_range(40, 10));
            c = (k == 0) ? lvl : 16'($urandom_range(300, 1));
            bus(8'h08, 32'(lvl), 1'b1);
            bus(8'h18, 32'h1F, 1'b1);
            bus(8'h1C, (k == 3) ? 32'h0 : 32'h4, 1'b1);
            @(posedge CLK);
            MOTOR_CURRENT_IN <= c;
            CUR_CHK <= (c > lvl);
            RUN_REQ <= (k % 2) ? 2'b10 : 2'b01;
            cyc(6);
            chk(32'(RUNNING_OUT), 32'h1);
            chk(32'(RUNNING_TERMINAL), 32'h1);
            chk(32'(CURRENT_DETECT_OUT), 32'(c > lvl));
            chk(32'(OPEN_COLLECTOR_TERMINAL), 32'(c > lvl));
            chk(32'(IRQ), (k == 3) ? 32'h0 : 32'h1);
            rd(8'h18, (c > lvl) ? 32'h14 : 32'h4);
            if (k == 1) begin
                // every code in both logics on one terminal
                for (int g = 0; g < 8; g++) begin
                    bus(8'h14, 32'(codes[g % 4]) + ((g > 3) ? 32'h64 : 32'h0),
                        1'b1);
                    cyc(3);
                    chk(32'(OPEN_COLLECTOR_TERMINAL),
                        32'(((g % 4 == 0) ? 1'b0 : (g % 4 == 3) ? (c > lvl) :
                        1'b1) ^ (g > 3)));
                end
                bus(8'h14, 32'h05, 1'b1);
                cyc(3);
                chk(32'(OPEN_COLLECTOR_TERMINAL), 32'h0);
                bus(8'h14, 32'h0C, 1'b1);
                bus(8'h0C, 32'hC7, 1'b1);
                cyc(3);
                chk(32'(FAULT_RELAY_TERMINAL), 32'h1);
                bus(8'h0C, 32'h63, 1'b1);
            end
            @(posedge CLK);
            RUN_REQ <= 2'b00;
            for (n = 0; n < 40 && RUNNING_OUT === 1'b1; n++) cyc(1);
            chk(32'(n >= 3 * TICK && n <= 4 * TICK + 5), 32'h1);
            bus(8'h18, 32'h1F, 1'b1);
            chk(32'(IRQ), 32'h0);
        end
        chk(32'(ALARM), 32'h0);
        // pin trip while running, start refused
        @(posedge CLK);
        RUN_REQ <= 2'b01;
        cyc(6);
        @(posedge CLK);
        PROTECT_TRIP_IN <= 1'b1;
        @(posedge CLK);
        PROTECT_TRIP_IN <= 1'b0;
        cyc(4);
        chk({FAULT_OUT, RUNNING_OUT, DRIVE_READY_OUT}, 32'h4);
        chk(32'(FAULT_RELAY_TERMINAL), 32'h1);
        rd(8'h04, 32'h38);
        // Start held against a tripped drive outlasts the allowance
        cyc(30);
        chk(32'(ALARM), 32'h1);
        RUN_REQ <= 2'b00;
        bus(8'h00, 32'h2, 1'b1);
        cyc(3);
        chk(32'(FAULT_OUT), 32'h0);
        bus(8'h00, 32'h1, 1'b1);
        cyc(4);
        chk(32'(FAULT_OUT), 32'h1);
        conclude();
    end
endmodule
